// ==== hdl/simd_alu.sv ====
`timescale 1ns/1ps
module simd_alu
    import simd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // issue port from decode
    input  wire logic        op_valid,
    input  wire logic [4:0]  op_class,
    input  wire logic [1:0]  op_size,
    input  wire logic [2:0]  dst_sel,
    input  wire logic [2:0]  src_sel,
    input  wire logic        src_ext,
    input  wire logic [63:0] ext_data,
    // floating-point side write into shared storage
    input  wire logic        fp_wr_en,
    input  wire logic [2:0]  fp_wr_sel,
    input  wire logic [63:0] fp_wr_data,
    // results
    output logic             done_reg,
    output logic             bad_op_reg,
    output logic [63:0]      result_reg,
    output logic             store_valid_reg,
    output logic [63:0]      store_data_reg,
    output logic [15:0]      tag_word_reg,
    output logic [31:0]      feature_reg
);
    //--------------------------------------------------------
    // operands
    //--------------------------------------------------------
    logic [63:0] rf [NUM_REGS];  // aliased with fp data stack
    wire  [63:0] a_op = rf[dst_sel];
    wire  [63:0] b_op = src_ext ? ext_data : rf[src_sel];
    wire op_e_sub = op_class == OP_SUB || op_class == OP_SUBS
                 || op_class == OP_SUBUS;
    wire sat_s = op_class == OP_ADDS || op_class == OP_SUBS;
    wire sat_u = op_class == OP_ADDUS || op_class == OP_SUBUS;
    wire is_eq = op_class == OP_CMPEQ;
    wire is_hi = op_class == OP_UNPKHI;
    // oversize counts clear or sign-fill the whole lane
    wire big_w = |b_op[63:4];
    wire big_d = |b_op[63:5];
    wire big_q = |b_op[63:6];

    // narrowing saturation helpers for pack
    function automatic logic [7:0] w2b_s(input logic [15:0] w);
        if ($signed(w) > $signed({8'h00, SB_MAX}))
            return SB_MAX;
        else if ($signed(w) < $signed({8'hff, SB_MIN}))
            return SB_MIN;
        else
            return w[7:0];
    endfunction
    function automatic logic [7:0] w2b_u(input logic [15:0] w);
        if (w[15])
            return UB_MIN;
        else if (|w[14:8])
            return UB_MAX;
        else
            return w[7:0];
    endfunction
    function automatic logic [15:0] d2w_s(input logic [31:0] d);
        if ($signed(d) > $signed({16'h0000, SW_MAX}))
            return SW_MAX;
        else if ($signed(d) < $signed({16'hffff, SW_MIN}))
            return SW_MIN;
        else
            return d[15:0];
    endfunction

    //--------------------------------------------------------
    // lane datapath
    //--------------------------------------------------------
    logic [63:0] b_ar, b_cmp, b_unp;
    logic [63:0] w_ar, w_cmp, w_unp, w_mlo, w_mhi;
    logic [63:0] w_sll, w_srl, w_sra, pk_wb, pk_ub;
    logic [63:0] d_ar, d_cmp, d_unp, d_mad;
    logic [63:0] d_sll, d_srl, d_sra, pk_dw;
    logic [31:0] prod [4];

    // every arithmetic lane is a separate slice: no carry crosses a boundary
    for (genvar i = 0; i < 8; i++) begin : g_lane
        wire [7:0] ab = a_op[8*i +: 8];
        wire [7:0] bb = b_op[8*i +: 8];
        wire [8:0] bs = op_e_sub ? {ab[7], ab} - {bb[7], bb}
                                 : {ab[7], ab} + {bb[7], bb};
        wire [8:0] bu = op_e_sub ? {1'b0, ab} - {1'b0, bb}
                                 : {1'b0, ab} + {1'b0, bb};
        wire bovf = bs[8] != bs[7];
        assign b_ar[8*i +: 8] =
            sat_s ? (bovf ? (bs[8] ? SB_MIN : SB_MAX)
                          : bs[7:0]) :
            sat_u ? (bu[8] ? (op_e_sub ? UB_MIN : UB_MAX)
                           : bu[7:0]) :
            bs[7:0];
        assign b_cmp[8*i +: 8] =
            (is_eq ? ab == bb : $signed(ab) > $signed(bb))
            ? UB_MAX : UB_MIN;
        assign b_unp[8*i +: 8] = (i % 2 == 0)
            ? (is_hi ? a_op[8*(i/2+4) +: 8] : a_op[8*(i/2) +: 8])
            : (is_hi ? b_op[8*(i/2+4) +: 8] : b_op[8*(i/2) +: 8]);
        if (i < 4) begin : g_word
            wire [15:0] aw = a_op[16*i +: 16];
            wire [15:0] bw = b_op[16*i +: 16];
            wire [16:0] ws = op_e_sub ? {aw[15], aw} - {bw[15], bw}
                                      : {aw[15], aw} + {bw[15], bw};
            wire [16:0] wu = op_e_sub ? {1'b0, aw} - {1'b0, bw}
                                      : {1'b0, aw} + {1'b0, bw};
            wire wovf = ws[16] != ws[15];
            assign w_ar[16*i +: 16] =
                sat_s ? (wovf ? (ws[16] ? SW_MIN
                                        : SW_MAX)
                              : ws[15:0]) :
                sat_u ? (wu[16] ? (op_e_sub ? UW_MIN : UW_MAX)
                                : wu[15:0]) :
                ws[15:0];
            assign w_cmp[16*i +: 16] =
                (is_eq ? aw == bw : $signed(aw) > $signed(bw))
                ? UW_MAX : UW_MIN;
            // widen first so the full 32-bit product is kept
            assign prod[i] = $signed({{16{aw[15]}}, aw})
                           * $signed({{16{bw[15]}}, bw});
            assign w_mlo[16*i +: 16] = prod[i][15:0];
            assign w_mhi[16*i +: 16] = prod[i][31:16];
            assign w_sll[16*i +: 16] = big_w ? UW_MIN : aw << b_op[3:0];
            assign w_srl[16*i +: 16] = big_w ? UW_MIN : aw >> b_op[3:0];
            assign w_sra[16*i +: 16] = big_w ? {16{aw[15]}}
                : 16'($signed(aw) >>> b_op[3:0]);
            assign pk_wb[8*i +: 8]     = w2b_s(aw);
            assign pk_wb[8*i+32 +: 8]  = w2b_s(bw);
            assign pk_ub[8*i +: 8]     = w2b_u(aw);
            assign pk_ub[8*i+32 +: 8]  = w2b_u(bw);
            assign w_unp[16*i +: 16] = (i % 2 == 0)
                ? (is_hi ? a_op[16*(i/2+2) +: 16]
                         : a_op[16*(i/2) +: 16])
                : (is_hi ? b_op[16*(i/2+2) +: 16]
                         : b_op[16*(i/2) +: 16]);
        end
        if (i < 2) begin : g_dword
            wire [31:0] ad = a_op[32*i +: 32];
            wire [31:0] bd = b_op[32*i +: 32];
            assign d_ar[32*i +: 32] = op_e_sub ? ad - bd : ad + bd;
            assign d_cmp[32*i +: 32] =
                (is_eq ? ad == bd : $signed(ad) > $signed(bd))
                ? {2{UW_MAX}} : {2{UW_MIN}};
            assign d_mad[32*i +: 32] = prod[2*i] + prod[2*i+1];
            assign d_sll[32*i +: 32] = big_d ? 32'h0 : ad << b_op[4:0];
            assign d_srl[32*i +: 32] = big_d ? 32'h0 : ad >> b_op[4:0];
            assign d_sra[32*i +: 32] = big_d ? {32{ad[31]}}
                : 32'($signed(ad) >>> b_op[4:0]);
            assign pk_dw[16*i +: 16]    = d2w_s(ad);
            assign pk_dw[16*i+32 +: 16] = d2w_s(bd);
            assign d_unp[32*i +: 32] = (i == 0)
                ? (is_hi ? a_op[63:32] : a_op[31:0])
                : (is_hi ? b_op[63:32] : b_op[31:0]);
        end
    end

    // whole-quadword shifts
    wire [63:0] q_sll = big_q ? 64'h0 : a_op << b_op[5:0];
    wire [63:0] q_srl = big_q ? 64'h0 : a_op >> b_op[5:0];

    // size selection shared by several classes
    wire [63:0] sel_ar  = op_size == SZ_BYTE ? b_ar
                        : op_size == SZ_WORD ? w_ar : d_ar;
    wire [63:0] sel_cmp = op_size == SZ_BYTE ? b_cmp
                        : op_size == SZ_WORD ? w_cmp : d_cmp;
    wire [63:0] sel_unp = op_size == SZ_BYTE ? b_unp
                        : op_size == SZ_WORD ? w_unp : d_unp;
    wire [63:0] sel_sll = op_size == SZ_WORD ? w_sll
                        : op_size == SZ_DWORD ? d_sll : q_sll;
    wire [63:0] sel_srl = op_size == SZ_WORD ? w_srl
                        : op_size == SZ_DWORD ? d_srl : q_srl;
    // doubleword moves zero the upper half; quad moves keep all
    wire [63:0] mv_ext  = op_size == SZ_DWORD
                        ? {32'h0, b_op[31:0]} : b_op;
    wire [63:0] mv_out  = op_size == SZ_DWORD
                        ? {32'h0, a_op[31:0]} : a_op;

    //--------------------------------------------------------
    // operation decode
    //--------------------------------------------------------
    logic [63:0] res;
    logic        legal;
    logic        wr_rf;
    logic        wr_st;
    wire  no_quad = op_size != SZ_QUAD;
    wire  bw_only = op_size == SZ_BYTE || op_size == SZ_WORD;
    wire  no_byte = op_size != SZ_BYTE;
    wire  mv_size = op_size == SZ_DWORD || op_size == SZ_QUAD;

    // one case covers all 47 operations by class and size
    always_comb begin
        res   = 64'h0;
        legal = 1'b1;
        wr_rf = 1'b1;
        wr_st = 1'b0;
        case (op_class_e'(op_class))
            OP_LOAD:   begin
                res   = mv_ext;
                legal = mv_size;
            end
            OP_MOVREG: begin
                res   = b_op;
                legal = op_size == SZ_QUAD;
            end
            OP_STORE, OP_TOGP: begin
                res   = mv_out;
                legal = mv_size;
                wr_rf = 1'b0;
                wr_st = 1'b1;
            end
            OP_ADD, OP_SUB: begin
                res   = sel_ar;
                legal = no_quad;
            end
            OP_ADDS, OP_SUBS, OP_ADDUS, OP_SUBUS: begin
                res   = sel_ar;
                legal = bw_only;
            end
            OP_MULLO:  begin
                res   = w_mlo;
                legal = op_size == SZ_WORD;
            end
            OP_MULHI:  begin
                res   = w_mhi;
                legal = op_size == SZ_WORD;
            end
            OP_MADD:   begin
                res   = d_mad;
                legal = op_size == SZ_WORD;
            end
            OP_CMPEQ, OP_CMPGT: begin
                res   = sel_cmp;
                legal = no_quad;
            end
            OP_PACKSS: begin
                res   = op_size == SZ_WORD ? pk_wb : pk_dw;
                legal = op_size == SZ_WORD || op_size == SZ_DWORD;
            end
            OP_PACKUS: begin
                res   = pk_ub;
                legal = op_size == SZ_WORD;
            end
            OP_UNPKLO, OP_UNPKHI: begin
                res   = sel_unp;
                legal = no_quad;
            end
            OP_AND:    res = a_op & b_op;
            OP_ANDN:   res = ~a_op & b_op;
            OP_OR:     res = a_op | b_op;
            OP_XOR:    res = a_op ^ b_op;
            OP_SLL:    begin
                res   = sel_sll;
                legal = no_byte;
            end
            OP_SRL:    begin
                res   = sel_srl;
                legal = no_byte;
            end
            OP_SRA:    begin
                res   = op_size == SZ_WORD ? w_sra : d_sra;
                legal = op_size == SZ_WORD || op_size == SZ_DWORD;
            end
            OP_EMPTY:  wr_rf = 1'b0;
            default:   begin
                legal = 1'b0;
                wr_rf = 1'b0;
            end
        endcase
    end

    wire fire   = op_valid && legal;
    wire do_emp = op_class == OP_EMPTY;

    //--------------------------------------------------------
    // shared register storage
    //--------------------------------------------------------
    // packed writes win over a same-cycle fp write to one entry
    always_ff @(posedge clock) begin
        if (fp_wr_en)
            rf[fp_wr_sel] <= fp_wr_data;
        if (fire && wr_rf)
            rf[dst_sel] <= res;
    end

    //--------------------------------------------------------
    // result and state outputs
    //--------------------------------------------------------
    // lane overflow never reaches a flag or fault; only a bad
    // opcode or size is reported, via bad_op_reg
    always_ff @(posedge clock) begin
        if (rst) begin
            done_reg        <= 1'b0;
            bad_op_reg      <= 1'b0;
            result_reg      <= 64'h0;
            store_valid_reg <= 1'b0;
            store_data_reg  <= 64'h0;
            tag_word_reg    <= TAGS_EMPTY;
            feature_reg     <= FEATURE_WORD;
        end else begin
            done_reg        <= fire;
            bad_op_reg      <= op_valid && !legal;
            store_valid_reg <= fire && wr_st;
            if (fire)
                result_reg <= res;
            if (fire && wr_st)
                store_data_reg <= res;
            if (fire)
                tag_word_reg <= do_emp ? TAGS_EMPTY
                                       : TAGS_VALID;
        end
    end
endmodule

// ==== inc/simd_pkg.sv ====
//------------------------------------------------------------
// Contract
// - operands split into eight bytes, four words or two dwords
// - moves carry whole 64-bit blocks (dword moves carry only the low 32 bits, upper half zeroed); lanes compute in parallel
// - lowest element sits at lowest memory address
// - wraparound keeps only the low bits of each lane
// - signed byte saturation clamps to 7f or 80
// - signed word positive overflow gives 7fff
// - signed word negative overflow gives 8000
// - unsigned saturation clamps to ff/ffff or zero
// - lane overflow raises no exception and touches no flags
// - 47 operations in eight groups are implemented
// - identification query reports feature bit 23 set
// - signed saturating word add works on four word lanes
// - byte operations handle all eight bytes at once
// - eight 64-bit registers shared with floating-point stack
// - every packed operation marks all tag fields valid 00
// - empty-state operation marks all tag fields empty 11
// - compares write all-ones or all-zero lanes, flags unchanged
//------------------------------------------------------------
package simd_pkg;
    localparam int   DATA_W      = 64;
    localparam int   NUM_REGS    = 8;
    localparam int   NUM_OPS     = 47;
    localparam int   FEATURE_BIT = 23;
    localparam int   TAG_W       = 16;

    // element size selector
    localparam logic [1:0] SZ_BYTE  = 2'h0;
    localparam logic [1:0] SZ_WORD  = 2'h1;
    localparam logic [1:0] SZ_DWORD = 2'h2;
    localparam logic [1:0] SZ_QUAD  = 2'h3;

    // saturation limits
    localparam logic [7:0]  SB_MAX = 8'h7f;
    localparam logic [7:0]  SB_MIN = 8'h80;
    localparam logic [15:0] SW_MAX = 16'h7fff;
    localparam logic [15:0] SW_MIN = 16'h8000;
    localparam logic [7:0]  UB_MAX = 8'hff;
    localparam logic [7:0]  UB_MIN = 8'h00;
    localparam logic [15:0] UW_MAX = 16'hffff;
    localparam logic [15:0] UW_MIN = 16'h0000;

    // tag word encodings
    localparam logic [1:0]  TAG_VALID = 2'h0;
    localparam logic [1:0]  TAG_EMPTY = 2'h3;
    localparam logic [15:0] TAGS_VALID = {8{TAG_VALID}};
    localparam logic [15:0] TAGS_EMPTY = {8{TAG_EMPTY}};
    localparam logic [31:0] FEATURE_WORD = 32'h0080_0000;

    // operation classes from issue logic
    typedef enum logic [4:0] {
        OP_LOAD   = 5'h00, OP_STORE  = 5'h01, OP_MOVREG = 5'h02,
        OP_TOGP   = 5'h03, OP_ADD    = 5'h04, OP_ADDS   = 5'h05,
        OP_ADDUS  = 5'h06, OP_SUB    = 5'h07, OP_SUBS   = 5'h08,
        OP_SUBUS  = 5'h09, OP_MULLO  = 5'h0a, OP_MULHI  = 5'h0b,
        OP_MADD   = 5'h0c, OP_CMPEQ  = 5'h0d, OP_CMPGT  = 5'h0e,
        OP_PACKSS = 5'h0f, OP_PACKUS = 5'h10, OP_UNPKLO = 5'h11,
        OP_UNPKHI = 5'h12, OP_AND    = 5'h13, OP_ANDN   = 5'h14,
        OP_OR     = 5'h15, OP_XOR    = 5'h16, OP_SLL    = 5'h17,
        OP_SRL    = 5'h18, OP_SRA    = 5'h19, OP_EMPTY  = 5'h1a
    } op_class_e;
endpackage

// ==== sim/simd_alu_sva.sv ====
`timescale 1ns/1ps
module simd_alu_sva
    import simd_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // issue port
    input wire logic        op_valid,
    input wire logic [4:0]  op_class,
    input wire logic [1:0]  op_size,
    input wire logic        src_ext,
    input wire logic [63:0] ext_data,
    // results
    input wire logic        done_reg,
    input wire logic        bad_op_reg,
    input wire logic [63:0] result_reg,
    input wire logic        store_valid_reg,
    input wire logic [63:0] store_data_reg,
    input wire logic [15:0] tag_word_reg,
    input wire logic [31:0] feature_reg
);
    //--------------------------------
    // common timing
    //--------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // ops that ended legally, split by whether they empty the state
    sequence s_empty_done;
        op_valid && op_class == OP_EMPTY ##1 done_reg;
    endsequence
    sequence s_packed_done;
        op_valid && op_class != OP_EMPTY ##1 done_reg;
    endsequence
    wire ld_quad = op_valid && op_class == OP_LOAD && op_size == SZ_QUAD;
    wire ld_dword = op_valid && op_class == OP_LOAD && op_size == SZ_DWORD;

    //--------------------------------
    // properties
    //--------------------------------
    property p_one_answer;
        op_valid |=> done_reg ^ bad_op_reg;
    endproperty
    property p_quiet;
        !op_valid |=> !done_reg && !bad_op_reg && !store_valid_reg;
    endproperty
    property p_empty_tags;
        s_empty_done |-> tag_word_reg == TAGS_EMPTY;
    endproperty
    property p_valid_tags;
        s_packed_done |-> tag_word_reg == TAGS_VALID;
    endproperty
    property p_refused_holds;
        bad_op_reg |-> $stable(tag_word_reg) && $stable(result_reg);
    endproperty
    property p_feature;
        feature_reg == FEATURE_WORD;
    endproperty
    property p_load_quad;
        ld_quad && src_ext |=> done_reg && result_reg == $past(ext_data);
    endproperty
    property p_load_dword;
        ld_dword && src_ext |=>
            result_reg == ($past(ext_data) & 64'h0000_0000_ffff_ffff);
    endproperty
    property p_store;
        op_valid && op_class == OP_STORE && op_size == SZ_QUAD |=>
            store_valid_reg && store_data_reg == result_reg;
    endproperty

    a_one_answer: assert property (p_one_answer)
        else $error("issued op gave no single answer");
    a_quiet: assert property (p_quiet)
        else $error("answer pulse with nothing issued");
    a_empty_tags: assert property (p_empty_tags)
        else $error("tags not empty after empty-state op");
    a_valid_tags: assert property (p_valid_tags)
        else $error("tags not valid after packed op");
    a_refused_holds: assert property (p_refused_holds)
        else $error("refused op changed state");
    a_feature: assert property (p_feature)
        else $error("feature word wrong");
    a_load_quad: assert property (p_load_quad)
        else $error("quad load not whole");
    a_load_dword: assert property (p_load_dword)
        else $error("dword load not zero extended");
    a_store: assert property (p_store)
        else $error("store data differs from register");
endmodule

bind simd_alu simd_alu_sva chk_u (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op_class(op_class),
    .op_size(op_size), .src_ext(src_ext), .ext_data(ext_data),
    .done_reg(done_reg), .bad_op_reg(bad_op_reg), .result_reg(result_reg),
    .store_valid_reg(store_valid_reg), .store_data_reg(store_data_reg),
    .tag_word_reg(tag_word_reg), .feature_reg(feature_reg)
);

// ==== sim/issue_model.sv ====
`timescale 1ns/1ps
module issue_model
    import simd_pkg::*;
(
    // clock
    input wire logic         clock,
    // issue port toward the block
    output logic             op_valid,
    output logic [4:0]       op_class,
    output logic [1:0]       op_size,
    output logic [2:0]       dst_sel,
    output logic [2:0]       src_sel,
    output logic             src_ext,
    output logic [63:0]      ext_data
);
    // quiet port at time zero
    initial begin
        {op_valid, op_class, op_size, dst_sel, src_sel, src_ext} = '0;
        ext_data = 64'h0;
    end
    // one op per call, launched just after an edge
    task automatic issue(input logic [4:0] c, input logic [1:0] s,
                         input logic [2:0] d, input logic [2:0] r,
                         input logic x, input logic [63:0] v);
        @(posedge clock);
        op_valid <= 1'b1;
        op_class <= c;
        op_size  <= s;
        dst_sel  <= d;
        src_sel  <= r;
        src_ext  <= x;
        ext_data <= v;
    endtask
    // released fields turn over so a stale value never passes for data
    task automatic idle();
        @(posedge clock);
        op_valid <= 1'b0;
        dst_sel  <= ~dst_sel;
        src_sel  <= ~src_sel;
        ext_data <= ~ext_data;
    endtask
endmodule

// ==== sim/packed_simd_integer_alu_tb.sv ====
`timescale 1ns/1ps
module packed_simd_integer_alu_tb
    import simd_pkg::*;
;
    //--------------------------------
    // signals
    //--------------------------------
    logic clock, rst, op_valid, src_ext, fp_wr_en, done_reg, bad_op_reg;
    logic store_valid_reg;
    logic [4:0] op_class;
    logic [1:0] op_size;
    logic [2:0] dst_sel, src_sel, fp_wr_sel;
    logic [63:0] ext_data, fp_wr_data, result_reg, store_data_reg;
    logic [15:0] tag_word_reg;
    logic [31:0] feature_reg;
    int miscompares = 0;
    int n_checks = 0;

    issue_model im_u (.clock(clock), .op_valid(op_valid),
        .op_class(op_class), .op_size(op_size), .dst_sel(dst_sel),
        .src_sel(src_sel), .src_ext(src_ext), .ext_data(ext_data));
    simd_alu dut_u (.clock(clock), .rst(rst), .op_valid(op_valid),
        .op_class(op_class), .op_size(op_size), .dst_sel(dst_sel),
        .src_sel(src_sel), .src_ext(src_ext), .ext_data(ext_data),
        .fp_wr_en(fp_wr_en), .fp_wr_sel(fp_wr_sel),
        .fp_wr_data(fp_wr_data), .done_reg(done_reg),
        .bad_op_reg(bad_op_reg), .result_reg(result_reg),
        .store_valid_reg(store_valid_reg),
        .store_data_reg(store_data_reg), .tag_word_reg(tag_word_reg),
        .feature_reg(feature_reg));

    // free-running core clock, 5 ns period
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    //--------------------------------
    // helpers
    //--------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // load both operands back to back, run op into r1, judge result
    task automatic run2(input logic [63:0] a, input logic [63:0] b,
                        input logic [4:0] c, input logic [1:0] s,
                        input logic [63:0] exp);
        im_u.issue(OP_LOAD, SZ_QUAD, 3'h1, 3'h0, 1'b1, a);
        im_u.issue(OP_LOAD, SZ_QUAD, 3'h2, 3'h0, 1'b1, b);
        im_u.issue(c, s, 3'h1, 3'h2, 1'b0, 64'h0);
        im_u.idle();
        #1;
        check(result_reg, exp);
        check({63'h0, done_reg}, 64'h1);
    endtask
    // store register r and judge the data leaving toward memory
    task automatic store(input logic [2:0] r, input logic [1:0] s,
                         input logic [63:0] exp);
        im_u.issue(OP_STORE, s, r, 3'h0, 1'b0, 64'h0);
        im_u.idle();
        #1;
        check({63'h0, store_valid_reg}, 64'h1);
        check(store_data_reg, exp);
    endtask

    //--------------------------------
    // scenarios
    //--------------------------------
    task automatic t_arith();
        logic [63:0] a, b;
        a = 64'h80ff_7f01_0000_ff7f;
        b = 64'h8001_0101_0000_0181;
        run2(a, b, OP_ADD, SZ_BYTE, 64'h0000_8002_0000_0000);
        run2(a, b, OP_ADDS, SZ_BYTE, 64'h8000_7f02_0000_0000);
        run2(a, b, OP_ADDUS, SZ_BYTE, 64'hffff_8002_0000_ffff);
        run2(a, b, OP_SUBUS, SZ_BYTE, 64'h00fe_7e00_0000_fe00);
        run2(a, b, OP_SUBS, SZ_BYTE, 64'h00fe_7e00_0000_fe7f);
        run2(a, b, OP_SUB, SZ_BYTE, 64'h00fe_7e00_0000_fefe);
        run2(a, b, OP_CMPEQ, SZ_BYTE, 64'hff00_00ff_ffff_0000);
        run2(a, b, OP_CMPGT, SZ_BYTE, 64'h0000_ff00_0000_00ff);
        a = 64'h7fff_8000_0001_ffff;
        b = 64'h0001_ffff_0002_ffff;
        run2(a, b, OP_ADDS, SZ_WORD, 64'h7fff_8000_0003_fffe);
        run2(a, b, OP_ADDUS, SZ_WORD, 64'h8000_ffff_0003_ffff);
        a = 64'hffff_ffff_0000_0001;
        b = 64'h0000_0001_ffff_ffff;
        run2(a, b, OP_ADD, SZ_DWORD, 64'h0);
    endtask
    // low byte of a stored quad belongs at the lowest address
    task automatic t_store();
        im_u.issue(OP_LOAD, SZ_QUAD, 3'h3, 3'h0, 1'b1, 64'h0807060504030201);
        store(3'h3, SZ_QUAD, 64'h0807_0605_0403_0201);
        check({56'h0, store_data_reg[7:0]}, 64'h01);
        store(3'h3, SZ_DWORD, 64'h0000_0000_0403_0201);
    endtask
    // refused ops leave r1 as the last dword add made it
    task automatic t_refuse();
        im_u.issue(OP_ADDS, SZ_DWORD, 3'h1, 3'h2, 1'b0, 64'h0);
        im_u.issue(5'h1f, SZ_BYTE, 3'h1, 3'h2, 1'b0, 64'h0);
        im_u.idle();
        #1;
        check({63'h0, bad_op_reg}, 64'h1);
        check({63'h0, done_reg}, 64'h0);
        store(3'h1, SZ_QUAD, 64'h0);
    endtask
    // floating-point side writes land in the same storage
    task automatic t_shared();
        @(posedge clock);
        fp_wr_en   <= 1'b1;
        fp_wr_sel  <= 3'h5;
        fp_wr_data <= 64'h1234_5678_9abc_def0;
        @(posedge clock);
        fp_wr_en   <= 1'b0;
        fp_wr_data <= ~fp_wr_data;
        im_u.issue(OP_MOVREG, SZ_QUAD, 3'h6, 3'h5, 1'b0, 64'h0);
        store(3'h6, SZ_QUAD, 64'h1234_5678_9abc_def0);
    endtask
    task automatic t_empty();
        im_u.issue(OP_EMPTY, SZ_QUAD, 3'h0, 3'h0, 1'b0, 64'h0);
        im_u.idle();
        #1;
        check({48'h0, tag_word_reg}, 64'hffff);
        run2(64'h1, 64'h2, OP_XOR, SZ_QUAD, 64'h3);
        check({48'h0, tag_word_reg}, 64'h0);
    endtask
    // remaining classes: multiply, pack, unpack, logic and shifts
    task automatic t_ops();
        logic [63:0] a, b;
        a = 64'h0004_fffe_8000_0003;
        b = 64'h0002_0003_8000_ffff;
        run2(a, b, OP_MULLO, SZ_WORD, 64'h0008_fffa_0000_fffd);
        run2(a, b, OP_MULHI, SZ_WORD, 64'h0000_ffff_4000_ffff);
        run2(a, b, OP_MADD, SZ_WORD, 64'h0000_0002_3fff_fffd);
        run2(a, b, OP_PACKSS, SZ_DWORD, 64'h7fff_8000_7fff_8000);
        run2(a, b, OP_PACKSS, SZ_WORD, 64'h0203_80ff_04fe_8003);
        run2(a, b, OP_PACKUS, SZ_WORD, 64'h0203_0000_0400_0003);
        run2(a, b, OP_UNPKLO, SZ_WORD, 64'h8000_8000_ffff_0003);
        run2(a, b, OP_UNPKHI, SZ_DWORD, 64'h0002_0003_0004_fffe);
        run2(a, b, OP_ANDN, SZ_QUAD, 64'h0002_0001_0000_fffc);
        run2(a, b, OP_OR, SZ_QUAD, 64'h0006_ffff_8000_ffff);
        a = 64'h8000_0001_f000_0010;
        run2(a, 64'h4, OP_SRA, SZ_WORD, 64'hf800_0000_ff00_0001);
        run2(a, 64'h4, OP_SLL, SZ_DWORD, 64'h0000_0010_0000_0100);
        run2(a, 64'h4, OP_SRL, SZ_QUAD, 64'h0800_0000_1f00_0001);
        run2(a, 64'h10, OP_SRA, SZ_WORD, 64'hffff_0000_ffff_0000);
    endtask

    //--------------------------------
    // main sequence and watchdog
    //--------------------------------
    initial begin
        rst = 1'b1;
        fp_wr_en = 1'b0;
        fp_wr_sel = 3'h0;
        fp_wr_data = 64'h0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1;
        check({32'h0, feature_reg}, {32'h0, FEATURE_WORD});
        check({63'h0, feature_reg[23]}, 64'h1);
        check({48'h0, tag_word_reg}, 64'hffff);
        t_arith();
        t_store();
        t_refuse();
        t_shared();
        t_empty();
        t_ops();
        conclude();
    end
    // a hang gives up well past the 124 or so cycles the tests need
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
endmodule
